// ===== acrc_pkg.sv
package acrc_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int SEL_W = 4;

    // Printed offsets are register indices; byte address is four times the index
    localparam logic [5:0] IDX_CLK_CTRL_TWO = 6'h2B;
    localparam logic [5:0] IDX_EDGE_POS = 6'h2C;
    localparam logic [5:0] IDX_FS_CODE_A = 6'h30;
    localparam logic [5:0] IDX_FS_CODE_B = 6'h32;
    localparam logic [5:0] IDX_REF_SRC_SEL = 6'h38;
    localparam int ADDR_LSB = 2;

    localparam int CTRL_W = 8;
    localparam int POS_W = 24;
    localparam int FS_W = 16;
    localparam int REFSEL_W = 8;

    localparam logic [7:0] CLK_CTRL_TWO_RST = 8'h11;
    localparam logic [23:0] EDGE_POS_RST = 24'h000000;
    localparam logic [15:0] FS_CODE_RST = 16'hA000;
    localparam logic [7:0] REF_SRC_SEL_RST = 8'h00;

    localparam int FB_GAIN_BIT = 4;
    localparam int NOISE_SUPPR_BIT = 2;
    localparam int SAMP_DEL_HI = 1;
    localparam int SAMP_DEL_LO = 0;
    localparam int REF_SRC_BIT = 0;

    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
endpackage : acrc_pkg

// ===== acrc_pos_if.sv
`timescale 1ns/10ps
interface acrc_pos_if;
    logic capture_stb;
    logic [acrc_pkg::POS_W-1:0] capture_val;
    logic [acrc_pkg::POS_W-1:0] position;

    modport regs (
        output capture_stb,
        output capture_val,
        input position
    );
    modport capture (
        input capture_stb,
        input capture_val,
        output position
    );
endinterface : acrc_pos_if

// ===== acrc_pos_capture.sv
`timescale 1ns/10ps
module acrc_pos_capture (
    input wire logic clk,
    input wire logic rst,
    acrc_pos_if.capture pos
);
    import acrc_pkg::*;

    logic [POS_W-1:0] position_r;

    // Only the capture logic loads this value; the bus has no path in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            position_r <= EDGE_POS_RST;
        end else if (pos.capture_stb) begin
            position_r <= pos.capture_val;
        end
    end

    assign pos.position = position_r;
endmodule : acrc_pos_capture

// ===== acrc_regs.sv
`timescale 1ns/10ps
module acrc_regs (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [acrc_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [acrc_pkg::SEL_W-1:0] WB_SEL_I,
    input wire logic [acrc_pkg::DATA_W-1:0] WB_DAT_I,
    output logic [acrc_pkg::DATA_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic POS_CAPTURE_STB,
    input wire logic [acrc_pkg::POS_W-1:0] POS_CAPTURE_VAL,
    output logic CLK_FB_GAIN_HIGH,
    output logic NOISE_SUPPRESS_EN,
    output logic [1:0] SAMPLE_CLOCK_DELAY_SEL,
    output logic [acrc_pkg::FS_W-1:0] FULL_SCALE_CODE_A,
    output logic [acrc_pkg::FS_W-1:0] FULL_SCALE_CODE_B,
    output logic REFERENCE_SOURCE_SELECT
);
    import acrc_pkg::*;

    // Byte-lane merge of write data into an existing register value
    function automatic logic [DATA_W-1:0] lane_merge(
        input logic [DATA_W-1:0] old_val,
        input logic [DATA_W-1:0] wdat,
        input logic [SEL_W-1:0] sel
    );
        logic [DATA_W-1:0] res;
        res = old_val;
        for (int i = 0; i < SEL_W; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = wdat[i*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] adr,
        input logic [5:0] idx
    );
        return adr[ADDR_W-1:ADDR_LSB] == idx;
    endfunction : addr_hit

    logic ack_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [CTRL_W-1:0] clk_ctrl_two_r;
    logic [FS_W-1:0] fs_code_a_r;
    logic [FS_W-1:0] fs_code_b_r;
    logic [REFSEL_W-1:0] ref_src_sel_r;
    logic req;
    logic wr_commit;
    logic [DATA_W-1:0] ctrl_merged;
    logic [DATA_W-1:0] fsa_merged;
    logic [DATA_W-1:0] fsb_merged;
    logic [DATA_W-1:0] ref_merged;

    acrc_pos_if pos_bus ();

    acrc_pos_capture u_pos_capture (
        .clk(SYS_CLK),
        .rst(RST),
        .pos(pos_bus.capture)
    );

    // Capture source is on this clock, so it goes straight in
    assign pos_bus.capture_stb = POS_CAPTURE_STB;
    assign pos_bus.capture_val = POS_CAPTURE_VAL;

    assign req = WB_CYC_I & WB_STB_I;
    // Writes land on the edge where the master sees ack, while the request is still held
    assign wr_commit = req & WB_WE_I & ack_r;

    assign ctrl_merged = lane_merge({24'h000000, clk_ctrl_two_r}, WB_DAT_I, WB_SEL_I);
    assign fsa_merged = lane_merge({16'h0000, fs_code_a_r}, WB_DAT_I, WB_SEL_I);
    assign fsb_merged = lane_merge({16'h0000, fs_code_b_r}, WB_DAT_I, WB_SEL_I);
    assign ref_merged = lane_merge({24'h000000, ref_src_sel_r}, WB_DAT_I, WB_SEL_I);

    // One wait state: ack one cycle after the request, dropped the cycle after
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    // Spare bits stay writable so software can read back what it wrote
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            clk_ctrl_two_r <= CLK_CTRL_TWO_RST;
        end else if (wr_commit && addr_hit(WB_ADR_I, IDX_CLK_CTRL_TWO)) begin
            clk_ctrl_two_r <= ctrl_merged[CTRL_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fs_code_a_r <= FS_CODE_RST;
        end else if (wr_commit && addr_hit(WB_ADR_I, IDX_FS_CODE_A)) begin
            // Codes below the recommended floor are stored as written
            fs_code_a_r <= fsa_merged[FS_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            fs_code_b_r <= FS_CODE_RST;
        end else if (wr_commit && addr_hit(WB_ADR_I, IDX_FS_CODE_B)) begin
            fs_code_b_r <= fsb_merged[FS_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            ref_src_sel_r <= REF_SRC_SEL_RST;
        end else if (wr_commit && addr_hit(WB_ADR_I, IDX_REF_SRC_SEL)) begin
            ref_src_sel_r <= ref_merged[REFSEL_W-1:0];
        end
    end

    always_comb begin
        rdata_nxt = UNMAPPED_READ;
        if (addr_hit(WB_ADR_I, IDX_CLK_CTRL_TWO)) begin
            rdata_nxt = {24'h000000, clk_ctrl_two_r};
        end else if (addr_hit(WB_ADR_I, IDX_EDGE_POS)) begin
            rdata_nxt = {8'h00, pos_bus.position};
        end else if (addr_hit(WB_ADR_I, IDX_FS_CODE_A)) begin
            rdata_nxt = {16'h0000, fs_code_a_r};
        end else if (addr_hit(WB_ADR_I, IDX_FS_CODE_B)) begin
            rdata_nxt = {16'h0000, fs_code_b_r};
        end else if (addr_hit(WB_ADR_I, IDX_REF_SRC_SEL)) begin
            rdata_nxt = {24'h000000, ref_src_sel_r};
        end
    end

    // Read data sampled with the request edge, so it is stable while ack is high
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            rdata_r <= UNMAPPED_READ;
        end else if (req && !ack_r) begin
            rdata_r <= rdata_nxt;
        end
    end

    // Outputs are registered copies so the analog controls never see bus glitches
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            CLK_FB_GAIN_HIGH <= CLK_CTRL_TWO_RST[FB_GAIN_BIT];
            NOISE_SUPPRESS_EN <= CLK_CTRL_TWO_RST[NOISE_SUPPR_BIT];
            SAMPLE_CLOCK_DELAY_SEL <= CLK_CTRL_TWO_RST[SAMP_DEL_HI:SAMP_DEL_LO];
            FULL_SCALE_CODE_A <= FS_CODE_RST;
            FULL_SCALE_CODE_B <= FS_CODE_RST;
            REFERENCE_SOURCE_SELECT <= REF_SRC_SEL_RST[REF_SRC_BIT];
        end else begin
            CLK_FB_GAIN_HIGH <= clk_ctrl_two_r[FB_GAIN_BIT];
            NOISE_SUPPRESS_EN <= clk_ctrl_two_r[NOISE_SUPPR_BIT];
            // Passed through unchecked; a non-one-hot code is software's concern
            SAMPLE_CLOCK_DELAY_SEL <= clk_ctrl_two_r[SAMP_DEL_HI:SAMP_DEL_LO];
            FULL_SCALE_CODE_A <= fs_code_a_r;
            FULL_SCALE_CODE_B <= fs_code_b_r;
            REFERENCE_SOURCE_SELECT <= ref_src_sel_r[REF_SRC_BIT];
        end
    end

    assign WB_DAT_O = rdata_r;
    assign WB_ACK_O = ack_r;
endmodule : acrc_regs

// ===== acrc_capture_model.sv
`timescale 1ns/10ps
module acrc_capture_model (
    input logic clk,
    input logic fire,
    input logic [23:0] val,
    output logic stb = 1'b0,
    output logic [23:0] pos = 24'h0
);
    always @(posedge clk) begin
        stb <= fire;
        // Value is only meaningful with the strobe, so it wanders otherwise
        pos <= fire ? val : ~pos;
    end
endmodule : acrc_capture_model

// ===== acrc_regs_assertions.sv
`timescale 1ns/10ps
module acrc_regs_assertions (
    input logic SYS_CLK,
    input logic RST,
    input logic WB_CYC_I,
    input logic WB_STB_I,
    input logic WB_WE_I,
    input logic [7:0] WB_ADR_I,
    input logic [3:0] WB_SEL_I,
    input logic [31:0] WB_DAT_I,
    input logic WB_ACK_O,
    input logic CLK_FB_GAIN_HIGH,
    input logic [1:0] SAMPLE_CLOCK_DELAY_SEL,
    input logic [15:0] FULL_SCALE_CODE_A,
    input logic [15:0] FULL_SCALE_CODE_B,
    input logic REFERENCE_SOURCE_SELECT
);
    logic [31:0] d1_r, d2_r;
    wire wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O;
    // Write data is gone when the field output settles, so keep two stages
    always_ff @(posedge SYS_CLK) begin
        d1_r <= WB_DAT_I;
        d2_r <= d1_r;
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    ack_reply_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O) else $error("ack late");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack held");
    ctrl_reset_a: assert property ($fell(RST) |-> CLK_FB_GAIN_HIGH && SAMPLE_CLOCK_DELAY_SEL == 2'h1)
        else $error("ctrl reset");
    code_reset_a: assert property ($fell(RST) |-> FULL_SCALE_CODE_A == 16'hA000 && FULL_SCALE_CODE_B == 16'hA000
        && !REFERENCE_SOURCE_SELECT) else $error("code reset");
    gain_write_a: assert property (wr && WB_ADR_I == 8'hAC && WB_SEL_I[0] |-> ##2 CLK_FB_GAIN_HIGH == d2_r[4])
        else $error("gain");
    delay_write_a: assert property (wr && WB_ADR_I == 8'hAC && WB_SEL_I[0] |-> ##2 SAMPLE_CLOCK_DELAY_SEL == d2_r[1:0])
        else $error("delay");
    code_a_lo_a: assert property (wr && WB_ADR_I == 8'hC0 && WB_SEL_I[0] |-> ##2 FULL_SCALE_CODE_A[7:0] == d2_r[7:0])
        else $error("code a");
    code_b_hi_a: assert property (wr && WB_ADR_I == 8'hC8 && WB_SEL_I[1] |-> ##2 FULL_SCALE_CODE_B[15:8] == d2_r[15:8])
        else $error("code b");
    ref_write_a: assert property (wr && WB_ADR_I == 8'hE0 && WB_SEL_I[0] |-> ##2 REFERENCE_SOURCE_SELECT == d2_r[0])
        else $error("ref sel");
    cover property (wr && WB_ADR_I == 8'hC0 && WB_SEL_I == 4'h2);
    cover property (wr && WB_ADR_I == 8'hB0);
    cover property ($fell(RST));
endmodule : acrc_regs_assertions
bind acrc_regs acrc_regs_assertions i_chk (.*);

// ===== adc_clock_range_config_regs_test.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module adc_clock_range_config_regs_test;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, ack, cs, gn, ns, rs;
    logic [7:0] adr = 8'h0;
    logic [3:0] sel = 4'h0;
    logic [31:0] dw = 32'h0, dr, seed = 32'hA6C562C8;
    logic [23:0] cv, pv = 24'h0;
    logic [1:0] dl;
    logic [15:0] fa, fb, c;
    logic [39:0] q[$];
    int bad_count = 0, num_checks = 0, cycles = 0;
    logic [7:0] ad[5] = '{8'hAC, 8'hB0, 8'hC0, 8'hC8, 8'hE0};
    logic [31:0] rv[5] = '{32'h11, 32'h0, 32'hA000, 32'hA000, 32'h0};
    acrc_regs i_dut (.SYS_CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(sel), .WB_DAT_I(dw), .WB_DAT_O(dr), .WB_ACK_O(ack), .POS_CAPTURE_STB(cs), .POS_CAPTURE_VAL(cv),
        .CLK_FB_GAIN_HIGH(gn), .NOISE_SUPPRESS_EN(ns), .SAMPLE_CLOCK_DELAY_SEL(dl), .FULL_SCALE_CODE_A(fa),
        .FULL_SCALE_CODE_B(fb), .REFERENCE_SOURCE_SELECT(rs));
    acrc_capture_model i_cap (.clk(clk), .fire(fire), .val(pv), .stb(cs), .pos(cv));
    always #10 clk = ~clk;
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, sel, dw} <= {2'b11, w, a, s, d};
        do @(posedge clk); while (ack !== 1'b1);
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back({a, e});
        wb(1'b0, a, 4'h0, 32'h0);
    endtask : rd
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge clk) begin
        if (ack === 1'b1 && cyc && !we) begin
            `CHK("read", q[0][31:0], dr)
            void'(q.pop_front());
        end
        cycles++;
        if (cycles == 2000) begin
            bad_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        foreach (ad[i]) rd(ad[i], rv[i]);
        repeat (4) begin
            c = 16'($random(seed));
            wb(1'b1, 8'hAC, 4'h1, {16'h0, c});
            rd(8'hAC, {24'h0, c[7:0]});
            `CHK("gain", c[4], gn)
            `CHK("noise", c[2], ns)
            `CHK("delay", c[1:0], dl)
        end
        c = 16'($random(seed)) | 16'h2000;
        wb(1'b1, 8'hC0, 4'h3, {16'h0, c});
        wb(1'b1, 8'hC8, 4'h3, {16'h0, c ^ 16'h0F0F});
        wb(1'b1, 8'hC0, 4'h2, 32'h00005A5A);
        rd(8'hC0, {16'h0, 8'h5A, c[7:0]});
        rd(8'hC8, {16'h0, c ^ 16'h0F0F});
        `CHK("code_a", {8'h5A, c[7:0]}, fa)
        `CHK("code_b", c ^ 16'h0F0F, fb)
        wb(1'b1, 8'hE0, 4'h1, 32'hFF);
        rd(8'hE0, 32'hFF);
        `CHK("ref", 1'b1, rs)
        pv <= 24'($random(seed));
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        rd(8'hB0, {8'h0, pv});
        wb(1'b1, 8'hB0, 4'hF, ~{8'h0, pv});
        rd(8'hB0, {8'h0, pv});
        wb(1'b1, 8'h04, 4'hF, 32'hFFFFFFFF);
        rd(8'h04, 32'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (ad[i]) rd(ad[i], rv[i]);
        wrap_up;
    end
endmodule : adc_clock_range_config_regs_test
